//--- rtl/rpsm_pkg.sv
// shared constants and types for the remappable pin select map
package rpsm_pkg;
  localparam int SEL_W        = 5;
  localparam int FIELD_N      = 16;
  localparam int MAP_REG_N    = 8;
  localparam int CTRL_IDX     = 8;
  localparam int OUT_FIELD0   = 6;
  localparam int OUT_PIN_N    = 10;
  localparam int PIN_N        = 26;
  localparam int PERIPH_FN_N  = 32;
  localparam int LANE_LO_LSB  = 0;
  localparam int LANE_HI_LSB  = 8;
  localparam int CTRL_LOCK    = 0;
  localparam int CTRL_MISMAT  = 1;
  // field slots: register r holds slot 2r in bits 4-0 and slot 2r+1 in bits 12-8
  localparam int F_UART_RX    = 0;
  localparam int F_UART_CTS   = 1;
  localparam int F_SPI_DATA   = 2;
  localparam int F_SPI_CLK    = 3;
  localparam int F_SPI_SS     = 4;
  localparam logic [SEL_W-1:0] SEL_MAX_PIN = 5'h19;
  localparam logic [SEL_W-1:0] SEL_PORT    = 5'h00;
  localparam logic [FIELD_N-1:0] FIELD_IMPL = 16'hffdf;
  localparam logic LOCK_RESET = 1'b0;
  typedef logic [FIELD_N-1:0][SEL_W-1:0] rpsm_cfg_t;
  // input slots reset to all ones, output slots and the empty slot to zero
  localparam rpsm_cfg_t CFG_RESET = {55'h0, 25'h1ffffff};
endpackage

//--- rtl/rpsm_shadow.sv
// shadow copy of the map configuration with continuous comparison
`timescale 1ns/100ps
module rpsm_shadow (
  input  wire logic              mclk,      // system clock
  input  wire logic              rst_n,     // synchronised reset, active low
  input  wire logic              load,      // live copy loads this cycle
  input  wire rpsm_pkg::rpsm_cfg_t loadCfg, // value the live copy loads
  input  wire rpsm_pkg::rpsm_cfg_t liveCfg, // live configuration
  output logic                   mismatch   // sticky mismatch reset request
);
  rpsm_pkg::rpsm_cfg_t shadowCfg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shadowCfg <= rpsm_pkg::CFG_RESET;
    end else if (load) begin
      shadowCfg <= loadCfg;
    end
  end

  // held until reset: the request must not vanish before the reset logic sees it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mismatch <= 1'b0;
    end else if (shadowCfg != liveCfg) begin
      mismatch <= 1'b1; // RULE_14
    end
  end

  a_shadow_mismatch: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_14
    (shadowCfg != liveCfg) |=> mismatch)
    else $error("shadow difference did not raise mismatch reset");
endmodule

//--- rtl/rpsm_top.sv
// remappable pin select map: input and output routing registers on wishbone
//
// Contract
// RULE_01: uart clear-to-send selector is bits 12-8 of the uart input map.
// RULE_02: uart receive selector is bits 4-0 of the uart input map.
// RULE_03: spi clock selector is bits 12-8 of the spi clock/data map.
// RULE_04: spi data-in selector is bits 4-0 of the spi clock/data map.
// RULE_05: spi slave-select selector is bits 4-0; bits 15-5 read zero.
// RULE_06: input code n routes remappable pin n; code zero is pin zero.
// RULE_07: input code 11001 routes pin 25, the highest pin.
// RULE_08: input code 11111 ties the peripheral input low.
// RULE_09: input selector bits reset to one, output selector bits to zero.
// RULE_10: bits 15-13 and 7-5 ignore writes and read zero.
// RULE_11: output map bits 4-0 drive the even pin, bits 12-8 the odd pin.
// RULE_12: five output maps cover pins 0-9 by peripheral function number.
// RULE_13: map writes are accepted only while the configuration lock is clear.
// RULE_14: shadow copies compared continuously; difference requests mismatch reset.
// RULE_15: input codes 11010 to 11110 also tie the input low.
// RULE_16: output selector zero leaves the pin under port control.
// RULE_17: selector takes effect after the write edge; routing is combinational.
`timescale 1ns/100ps
module rpsm_top #(
  parameter int ADDR_W = 8                       // wishbone byte address width
) (
  input  wire logic                     mclk,            // system clock, 250 MHz
  input  wire logic                     arst_n,          // async reset, active low
  input  wire logic                     wb_cyc_i,        // wishbone cycle
  input  wire logic                     wb_stb_i,        // wishbone strobe
  input  wire logic                     wb_we_i,         // wishbone write enable
  input  wire logic [ADDR_W-1:0]        wb_adr_i,        // wishbone byte address
  input  wire logic [3:0]               wb_sel_i,        // wishbone byte selects
  input  wire logic [31:0]              wb_dat_i,        // wishbone write data
  output logic      [31:0]              wb_dat_o,        // wishbone read data
  output logic                          wb_ack_o,        // wishbone acknowledge
  input  wire logic [rpsm_pkg::PIN_N-1:0] remappablePinIn, // pin levels, async
  input  wire logic [rpsm_pkg::PERIPH_FN_N-1:0] periphFuncOut, // function outputs
  input  wire logic [rpsm_pkg::OUT_PIN_N-1:0] portData,  // ordinary port drive
  output logic [rpsm_pkg::OUT_PIN_N-1:0] pinOut,         // level toward each pin
  output logic [rpsm_pkg::OUT_PIN_N-1:0] pinPeriphDrive, // pin owned by a function
  output logic                          uartClearToSendIn, // to uart
  output logic                          uartReceiveIn,   // to uart
  output logic                          spiClockIn,      // to spi
  output logic                          spiSerialDataIn, // to spi
  output logic                          spiSlaveSelectIn, // to spi
  output logic                          cfgMismatchReset // mismatch reset request
);
  localparam int WIDX_W = ADDR_W - 2;

  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W must be at least 6 to reach the control register");
  end

  // reset release
  logic [1:0] rstPipe;
  logic       rstSync_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  // pin synchroniser
  logic [rpsm_pkg::PIN_N-1:0] pinMeta;
  logic [rpsm_pkg::PIN_N-1:0] pinSync;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= remappablePinIn;
      pinSync <= pinMeta;
    end
  end

  function automatic logic isReg(input logic [WIDX_W-1:0] idx, input int k);
    isReg = (idx == WIDX_W'(k));
  endfunction

  // codes above the last pin name nothing and read as ground
  function automatic logic routeIn(input logic [rpsm_pkg::SEL_W-1:0] code,
                                   input logic [rpsm_pkg::PIN_N-1:0] pins);
    if (code <= rpsm_pkg::SEL_MAX_PIN) begin
      routeIn = pins[code];
    end else begin
      routeIn = 1'b0;
    end
  endfunction

  // bus decode
  logic [WIDX_W-1:0]   wordIdx;
  logic                access;
  logic                wbWrite;
  logic                lock;
  logic                cfgLoad;
  rpsm_pkg::rpsm_cfg_t cfg;
  rpsm_pkg::rpsm_cfg_t next_cfg;

  assign wordIdx = wb_adr_i[ADDR_W-1:2];
  assign access  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = access && wb_we_i;
  assign cfgLoad = wbWrite && !lock; // RULE_13

  for (genvar f = 0; f < rpsm_pkg::FIELD_N; f++) begin : g_field
    localparam int LSB = (f % 2 == 0) ? rpsm_pkg::LANE_LO_LSB : rpsm_pkg::LANE_HI_LSB;
    always_comb begin
      next_cfg[f] = cfg[f];
      if (cfgLoad && rpsm_pkg::FIELD_IMPL[f] && isReg(wordIdx, f / 2) && wb_sel_i[f % 2]) begin
        next_cfg[f] = wb_dat_i[LSB +: rpsm_pkg::SEL_W]; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_11
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfg <= rpsm_pkg::CFG_RESET; // RULE_09
    end else if (cfgLoad) begin
      cfg <= next_cfg; // RULE_17
    end
  end

  // the lock stays writable so software can open a write session
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lock <= rpsm_pkg::LOCK_RESET;
    end else if (wbWrite && isReg(wordIdx, rpsm_pkg::CTRL_IDX) && wb_sel_i[0]) begin
      lock <= wb_dat_i[rpsm_pkg::CTRL_LOCK];
    end
  end

  // one wait state: ack rises after the request edge, falls the cycle after
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wb_dat_o <= 32'h0;
    end else if (access) begin
      wb_dat_o <= 32'h0; // RULE_05 RULE_10
      for (int r = 0; r < rpsm_pkg::MAP_REG_N; r++) begin
        if (isReg(wordIdx, r)) begin
          wb_dat_o[rpsm_pkg::LANE_LO_LSB +: rpsm_pkg::SEL_W] <= cfg[2 * r];
          wb_dat_o[rpsm_pkg::LANE_HI_LSB +: rpsm_pkg::SEL_W] <= cfg[2 * r + 1];
        end
      end
      if (isReg(wordIdx, rpsm_pkg::CTRL_IDX)) begin
        wb_dat_o[rpsm_pkg::CTRL_LOCK]   <= lock;
        wb_dat_o[rpsm_pkg::CTRL_MISMAT] <= cfgMismatchReset;
      end
    end
  end

  rpsm_shadow u_shadow (
    .mclk     (mclk),
    .rst_n    (rstSync_n),
    .load     (cfgLoad),
    .loadCfg  (next_cfg),
    .liveCfg  (cfg),
    .mismatch (cfgMismatchReset)
  );

  // input routing: purely combinational from the held selectors
  assign uartClearToSendIn = routeIn(cfg[rpsm_pkg::F_UART_CTS], pinSync); // RULE_01
  assign uartReceiveIn     = routeIn(cfg[rpsm_pkg::F_UART_RX], pinSync);  // RULE_02
  assign spiClockIn        = routeIn(cfg[rpsm_pkg::F_SPI_CLK], pinSync);  // RULE_03
  assign spiSerialDataIn   = routeIn(cfg[rpsm_pkg::F_SPI_DATA], pinSync); // RULE_04
  assign spiSlaveSelectIn  = routeIn(cfg[rpsm_pkg::F_SPI_SS], pinSync);   // RULE_05 RULE_06 RULE_07 RULE_08 RULE_15

  // output routing, one selector per pin
  for (genvar p = 0; p < rpsm_pkg::OUT_PIN_N; p++) begin : g_pin
    logic [rpsm_pkg::SEL_W-1:0] fn;
    assign fn = cfg[rpsm_pkg::OUT_FIELD0 + p];
    assign pinPeriphDrive[p] = (fn != rpsm_pkg::SEL_PORT); // RULE_16
    assign pinOut[p] = (fn == rpsm_pkg::SEL_PORT) ? portData[p] : periphFuncOut[fn]; // RULE_12
  end

  // checks
  logic [rpsm_pkg::SEL_W-1:0] wrLo;
  logic [rpsm_pkg::SEL_W-1:0] wrHi;
  logic [rpsm_pkg::SEL_W-1:0] rdLo;
  logic [rpsm_pkg::SEL_W-1:0] rdHi;

  assign wrLo = wb_dat_i[rpsm_pkg::LANE_LO_LSB +: rpsm_pkg::SEL_W];
  assign wrHi = wb_dat_i[rpsm_pkg::LANE_HI_LSB +: rpsm_pkg::SEL_W];
  assign rdLo = wb_dat_o[rpsm_pkg::LANE_LO_LSB +: rpsm_pkg::SEL_W];
  assign rdHi = wb_dat_o[rpsm_pkg::LANE_HI_LSB +: rpsm_pkg::SEL_W];

  a_reset_values: assert property (@(posedge mclk) // RULE_09
    $rose(rstSync_n) |-> (cfg == rpsm_pkg::CFG_RESET) && !lock)
    else $error("configuration not at reset value after release");

  a_uart_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_01
    (cfgLoad && isReg(wordIdx, 0) && wb_sel_i[1])
    |=> cfg[rpsm_pkg::F_UART_CTS] == $past(wb_dat_i[12:8]))
    else $error("uart cts selector did not take written value");

  a_rx_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_02
    (cfgLoad && isReg(wordIdx, rpsm_pkg::F_UART_RX / 2) && wb_sel_i[0])
    |=> cfg[rpsm_pkg::F_UART_RX] == $past(wrLo))
    else $error("uart receive selector did not take written value");

  a_sck_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_03
    (cfgLoad && isReg(wordIdx, rpsm_pkg::F_SPI_CLK / 2) && wb_sel_i[1])
    |=> cfg[rpsm_pkg::F_SPI_CLK] == $past(wrHi))
    else $error("spi clock selector did not take written value");

  a_sdi_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_04
    (cfgLoad && isReg(wordIdx, rpsm_pkg::F_SPI_DATA / 2) && wb_sel_i[0])
    |=> cfg[rpsm_pkg::F_SPI_DATA] == $past(wrLo))
    else $error("spi data selector did not take written value");

  a_ss_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_05
    (cfgLoad && isReg(wordIdx, rpsm_pkg::F_SPI_SS / 2) && wb_sel_i[0])
    |=> cfg[rpsm_pkg::F_SPI_SS] == $past(wrLo))
    else $error("spi select selector did not take written value");

  a_even_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_11
    (cfgLoad && isReg(wordIdx, rpsm_pkg::OUT_FIELD0 / 2) && wb_sel_i[0])
    |=> cfg[rpsm_pkg::OUT_FIELD0] == $past(wrLo))
    else $error("even pin selector did not take written value");

  a_odd_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_11
    (cfgLoad && isReg(wordIdx, rpsm_pkg::OUT_FIELD0 / 2) && wb_sel_i[1])
    |=> cfg[rpsm_pkg::OUT_FIELD0 + 1] == $past(wrHi))
    else $error("odd pin selector did not take written value");

  a_write_settle: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_17
    cfgLoad |=> cfg == $past(next_cfg))
    else $error("map did not settle on the edge after the write");

  a_map_needs_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_13
    $changed(cfg) |-> $past(cfgLoad))
    else $error("map changed without an accepted write");

  a_lock_blocks: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_13
    (wbWrite && lock) |=> $stable(cfg))
    else $error("map changed while locked");

  a_lock_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_13
    (wbWrite && isReg(wordIdx, rpsm_pkg::CTRL_IDX) && wb_sel_i[0])
    |=> lock == $past(wb_dat_i[rpsm_pkg::CTRL_LOCK]))
    else $error("lock bit did not take written value");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_10
    (wb_ack_o && !$past(wb_we_i))
    |-> (wb_dat_o[15:13] == 3'h0) && (wb_dat_o[7:5] == 3'h0)
        && (wb_dat_o[31:16] == 16'h0))
    else $error("reserved bits read nonzero");

  a_ss_upper_zero: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_05
    $past(access && !wb_we_i && isReg(wordIdx, 2)) |-> wb_dat_o[15:5] == 11'h0)
    else $error("slave select register upper bits nonzero");

  a_empty_slot: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_05
    cfg[rpsm_pkg::F_SPI_SS + 1] == '0)
    else $error("unimplemented selector slot holds a value");

  a_read_uart: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_01
    (access && !wb_we_i && isReg(wordIdx, rpsm_pkg::F_UART_RX / 2))
    |=> rdHi == $past(cfg[rpsm_pkg::F_UART_CTS]) && rdLo == $past(cfg[rpsm_pkg::F_UART_RX]))
    else $error("uart input map read does not show the selectors");

  a_read_ctrl: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_14
    (access && !wb_we_i && isReg(wordIdx, rpsm_pkg::CTRL_IDX))
    |=> (wb_dat_o[rpsm_pkg::CTRL_LOCK] == $past(lock))
        && (wb_dat_o[rpsm_pkg::CTRL_MISMAT] == $past(cfgMismatchReset)))
    else $error("control read does not show lock and mismatch");

  a_route_pin: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_06
    (cfg[rpsm_pkg::F_UART_RX] <= rpsm_pkg::SEL_MAX_PIN)
    |-> uartReceiveIn == pinSync[cfg[rpsm_pkg::F_UART_RX]])
    else $error("uart receive not routed from selected pin");

  a_route_cts: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_01
    (cfg[rpsm_pkg::F_UART_CTS] <= rpsm_pkg::SEL_MAX_PIN)
    |-> uartClearToSendIn == pinSync[cfg[rpsm_pkg::F_UART_CTS]])
    else $error("uart cts not routed from selected pin");

  a_route_sck: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_03
    (cfg[rpsm_pkg::F_SPI_CLK] <= rpsm_pkg::SEL_MAX_PIN)
    |-> spiClockIn == pinSync[cfg[rpsm_pkg::F_SPI_CLK]])
    else $error("spi clock not routed from selected pin");

  a_route_top: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_07
    (cfg[rpsm_pkg::F_SPI_DATA] == rpsm_pkg::SEL_MAX_PIN)
    |-> spiSerialDataIn == pinSync[rpsm_pkg::SEL_MAX_PIN])
    else $error("spi data not routed from the highest pin");

  a_route_ss: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_05
    (cfg[rpsm_pkg::F_SPI_SS] <= rpsm_pkg::SEL_MAX_PIN)
    |-> spiSlaveSelectIn == pinSync[cfg[rpsm_pkg::F_SPI_SS]])
    else $error("spi select not routed from selected pin");

  a_route_tie: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_08
    (cfg[rpsm_pkg::F_SPI_CLK] > rpsm_pkg::SEL_MAX_PIN) |-> !spiClockIn)
    else $error("spi clock not tied low for no-pin code");

  a_tie_code: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_08
    (cfg[rpsm_pkg::F_SPI_SS] == '1) |-> !spiSlaveSelectIn)
    else $error("spi select not tied low for the ground code");

  a_unnamed_low: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_15
    (cfg[rpsm_pkg::F_UART_CTS] > rpsm_pkg::SEL_MAX_PIN) && (cfg[rpsm_pkg::F_UART_CTS] != '1)
    |-> !uartClearToSendIn)
    else $error("uart cts not held low for a code naming no pin");

  a_out_port: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_16
    (cfg[rpsm_pkg::OUT_FIELD0] == rpsm_pkg::SEL_PORT)
    |-> !pinPeriphDrive[0] && (pinOut[0] == portData[0]))
    else $error("pin 0 not under port control at selector zero");

  a_out_func: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_11
    (cfg[rpsm_pkg::OUT_FIELD0 + 1] != rpsm_pkg::SEL_PORT)
    |-> pinPeriphDrive[1] && (pinOut[1] == periphFuncOut[cfg[rpsm_pkg::OUT_FIELD0 + 1]]))
    else $error("pin 1 not driven by selected function");

  a_ack_timing: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_17
    access |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request or not dropped");

  a_ack_source: assert property (@(posedge mclk) disable iff (!rstSync_n) // RULE_17
    wb_ack_o |-> $past(access))
    else $error("ack given without a request");
endmodule

//--- test/rpsm_far_model.sv
// far-side model: remappable pin levels and peripheral function outputs
`timescale 1ns/100ps
module rpsm_far_model (
  input  wire logic        mclk,      // system clock
  input  wire logic [25:0] nextPins,  // pin levels to present next
  input  wire logic [31:0] nextFuncs, // function outputs to present next
  output logic      [25:0] pins,      // remappable pin levels
  output logic      [31:0] funcs      // peripheral function outputs
);
  // outputs move just after the clock edge, as on-chip peripherals would
  always_ff @(posedge mclk) begin
    pins  <= nextPins;
    funcs <= nextFuncs;
  end
endmodule

//--- test/rpsm_top_bench.sv
// self-checking bench for the remappable pin select map
`timescale 1ns/100ps
`define CHK(nm, e, s) begin cmpCount++; if ((s) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, s); end end
module rpsm_top_bench;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, expV;
  logic        ack, cts, rx, sck, sdi, ss, mism;
  logic [25:0] pins, nextPins = 26'h0;
  logic [31:0] funcs, nextFuncs = 32'h0;
  logic [9:0]  port = 10'h0, pout, pdrv;
  logic [15:0] rnd = 16'h0032;
  logic [4:0]  hi, lo;
  logic [31:0] expQ[$];
  logic [3:0]  laneSel = 4'h3;
  int          fails = 0, cmpCount = 0, cycles = 0;
  localparam logic [4:0] CODES [7] = '{5'h00, 5'h01, 5'h0d, 5'h19, 5'h1a, 5'h1e, 5'h1f};
  localparam logic [31:0] RESET_VAL [9] = '{32'h1f1f, 32'h1f1f, 32'h001f, 0, 0, 0, 0, 0, 0};

  rpsm_top #(.ADDR_W(8)) DUT (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .remappablePinIn(pins), .periphFuncOut(funcs), .portData(port),
    .pinOut(pout), .pinPeriphDrive(pdrv), .uartClearToSendIn(cts), .uartReceiveIn(rx),
    .spiClockIn(sck), .spiSerialDataIn(sdi), .spiSlaveSelectIn(ss), .cfgMismatchReset(mism));
  rpsm_far_model far (.mclk(mclk), .nextPins(nextPins), .nextFuncs(nextFuncs), .pins(pins),
    .funcs(funcs));

  initial begin
    forever #2 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // codes beyond the last pin name nothing, so the input reads low
  function automatic logic pinOf(input logic [4:0] c);
    return (c <= 5'h19) ? pins[c] : 1'b0;
  endfunction

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one classic cycle; the idle edge afterwards keeps cyc low for a full cycle
  task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= laneSel;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wbRead(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    wbCycle(1'b0, a, 32'h0);
  endtask

  always @(posedge mclk) begin
    if (ack === 1'b1 && cyc && !we) begin
      expV = (expQ.size() > 0) ? expQ.pop_front() : 32'hdeadbeef;
      `CHK("readData", expV, rdat)
    end
    cycles++;
    if (cycles == 5000) begin
      fails++;
      testDone();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (RESET_VAL[i]) wbRead(8'(4 * i), RESET_VAL[i]);
    `CHK("routedIn", 5'h00, {cts, rx, sck, sdi, ss})
    `CHK("pinDrive", 10'h000, pdrv)
    `CHK("pinOut", port, pout)
    $display("test reset done");
    for (int i = 0; i < 3; i++) wbCycle(1'b1, 8'(4 * i), 32'hffffffff);
    for (int i = 0; i < 3; i++) wbRead(8'(4 * i), RESET_VAL[i]);
    $display("test reserved done");
    foreach (CODES[i]) begin
      rnd = lfsrNext(rnd);
      nextPins <= {rnd[9:0], ~rnd};
      hi = CODES[i];
      lo = CODES[(i + 3) % 7];
      wbCycle(1'b1, 8'h00, {19'h0, hi, 3'h0, lo});
      wbCycle(1'b1, 8'h04, {19'h0, lo, 3'h0, hi});
      wbCycle(1'b1, 8'h08, {27'h0, hi});
      wbRead(8'h00, {19'h0, hi, 3'h0, lo});
      `CHK("uartCts", pinOf(hi), cts)
      `CHK("uartRx", pinOf(lo), rx)
      `CHK("spiClock", pinOf(lo), sck)
      `CHK("spiData", pinOf(hi), sdi)
      `CHK("spiSelect", pinOf(hi), ss)
    end
    $display("test input routing done");
    for (int r = 0; r < 5; r++) begin
      rnd = lfsrNext(rnd);
      nextFuncs <= {rnd, ~rnd};
      port <= rnd[13:4];
      hi = rnd[12:8];
      lo = (r == 0) ? 5'h00 : rnd[4:0];
      wbCycle(1'b1, 8'(12 + 4 * r), {19'h0, hi, 3'h0, lo});
      `CHK("evenPin", (lo == 5'h00) ? port[2 * r] : funcs[lo], pout[2 * r])
      `CHK("oddPin", (hi == 5'h00) ? port[2 * r + 1] : funcs[hi], pout[2 * r + 1])
      `CHK("pinDrive", {hi != 5'h00, lo != 5'h00}, pdrv[2 * r +: 2])
    end
    $display("test output routing done");
    wbCycle(1'b1, 8'h20, 32'h1);
    wbCycle(1'b1, 8'h1c, {19'h0, ~hi, 3'h0, ~lo});
    wbRead(8'h1c, {19'h0, hi, 3'h0, lo});
    wbRead(8'h20, 32'h1);
    wbCycle(1'b1, 8'h20, 32'h0);
    wbCycle(1'b1, 8'h1c, 32'h0);
    // low lane only: the odd pin's selector must keep its cleared value
    laneSel = 4'h1;
    wbCycle(1'b1, 8'h1c, 32'h00001f0a);
    laneSel = 4'h3;
    wbRead(8'h1c, 32'h0000000a);
    `CHK("laneDrive", 2'h1, pdrv[9:8])
    wbRead(8'h24, 32'h0);
    `CHK("mismatch", 1'b0, mism)
    $display("test lock done");
    repeat (2) @(posedge mclk);
    testDone();
  end
endmodule
